// >>> design/pcm_bridge.sv
module pcm_bridge (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Settings from control software
	input wire logic output_enable_flag,
	input wire logic peak_mode_select,
	input wire logic [pcm_pkg::CNT_W-1:0] phase_shift_setting,
	input wire logic [pcm_pkg::REF_W-1:0] peak_ref,
	input wire logic [pcm_pkg::SLOPE_W-1:0] slope_step,
	input wire logic [pcm_pkg::DB_W-1:0] master_deadband,
	input wire logic [pcm_pkg::DB_W-1:0] active_to_passive_deadband,
	input wire logic [pcm_pkg::DB_W-1:0] rect_deadband,
	// Sense inputs from pins
	input wire logic [pcm_pkg::REF_W-1:0] i_sense,
	input wire logic [pcm_pkg::REF_W-1:0] adc_sample,
	// Gate drives
	output logic q1,
	output logic q4,
	output logic q2,
	output logic q3,
	output logic q5,
	output logic q6,
	// Status
	output logic ctrl_irq,
	output logic trip_seen,
	output logic [pcm_pkg::REF_W-1:0] adc_monitor
);
	import pcm_pkg::*;

	typedef struct packed {
		logic [REF_W-1:0] isen_s1;
		logic [REF_W-1:0] isen_s2;
		logic [REF_W-1:0] adc_s1;
		logic [REF_W-1:0] adc_s2;
		logic [CNT_W-1:0] cnt;
		logic up;
		logic done;
		logic leg2_b;
		logic [DB_W-1:0] rect_db;
		logic irq;
		logic trip;
		logic cmp_prev;
		logic [REF_W-1:0] adc_mon;
	} pcm_bridge_s;

	pcm_bridge_s cur;
	pcm_bridge_s next_cur;

	pcm_pair_if master_if ();
	pcm_pair_if leg2_if ();
	pcm_pair_if rect_if ();

	logic [CNT_W-1:0] half_pos;
	logic [REF_W+SLOPE_W-1:0] ramp_drop;
	logic [REF_W-1:0] ramp_ref;
	logic cmp_hit;
	logic half_start;
	logic half_end;
	logic flip;

	always_comb begin
		half_pos = cur.up ? cur.cnt : (HALF_TOP - cur.cnt);
		ramp_drop = (REF_W+SLOPE_W)'(slope_step) * (REF_W+SLOPE_W)'(half_pos);
		if (ramp_drop >= (REF_W+SLOPE_W)'(peak_ref)) begin
			ramp_ref = SAMPLE_RESET;
		end else begin
			ramp_ref = peak_ref - ramp_drop[REF_W-1:0];
		end
		cmp_hit = (cur.isen_s2 >= ramp_ref);
	end

	always_comb begin
		next_cur = cur;
		// Sense pins pass two stages first
		next_cur.isen_s1 = i_sense;
		next_cur.isen_s2 = cur.isen_s1;
		next_cur.adc_s1 = adc_sample;
		next_cur.adc_s2 = cur.adc_s1;
		next_cur.irq = 1'b0;
		next_cur.cmp_prev = cmp_hit;
		half_start = (cur.cnt == CNT_ZERO) || (cur.cnt == HALF_TOP);
		half_end = (half_pos == HALF_LAST);
		flip = 1'b0;

		if (cur.up) begin
			if (cur.cnt == HALF_LAST) begin
				next_cur.cnt = HALF_TOP;
				next_cur.up = 1'b0;
			end else begin
				next_cur.cnt = cur.cnt + 1'b1;
			end
		end else begin
			if (cur.cnt == CNT_ONE) begin
				next_cur.cnt = CNT_ZERO;
				next_cur.up = 1'b1;
				next_cur.irq = 1'b1;
				// rectifier setting taken at period edge
				next_cur.rect_db = rect_deadband;
			end else begin
				next_cur.cnt = cur.cnt - 1'b1;
			end
		end

		// period is twice the half count
		if (half_start) begin
			next_cur.done = 1'b0;
			next_cur.trip = 1'b0;
		end

		if (!cur.done || half_start) begin
			if (peak_mode_select) begin
				// comparator trip acts on outputs
				// Rising edge only: stale sense across half start must not trip
				flip = cmp_hit && !cur.cmp_prev && output_enable_flag;
				next_cur.trip = flip;
			end else begin
				flip = (half_pos == phase_shift_setting);
			end
			// Without a trip or phase match, switch at the half end
			if (half_end) begin
				flip = 1'b1;
			end
		end

		if (flip) begin
			next_cur.leg2_b = !cur.leg2_b;
			next_cur.done = 1'b1;
		end

		if (cur.irq) begin
			next_cur.adc_mon = cur.adc_s2;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.up <= 1'b1;
			cur.rect_db <= DB_RESET;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	assign master_if.run = output_enable_flag;
	assign master_if.sel_b = !cur.up;
	assign master_if.dead = master_deadband;

	assign leg2_if.run = output_enable_flag;
	assign leg2_if.sel_b = cur.leg2_b;
	assign leg2_if.dead = active_to_passive_deadband;

	assign rect_if.run = output_enable_flag;
	assign rect_if.sel_b = cur.leg2_b;
	assign rect_if.dead = cur.rect_db;

	pcm_pair u_master (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.pif(master_if)
	);

	pcm_pair u_leg2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.pif(leg2_if)
	);

	pcm_pair u_rect (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.pif(rect_if)
	);

	assign q1 = master_if.out_a;
	assign q4 = master_if.out_b;
	assign q2 = leg2_if.out_a;
	assign q3 = leg2_if.out_b;
	assign q5 = rect_if.out_a;
	assign q6 = rect_if.out_b;
	assign ctrl_irq = cur.irq;
	assign trip_seen = cur.trip;
	assign adc_monitor = cur.adc_mon;
endmodule : pcm_bridge

// >>> design/pcm_pair.sv
module pcm_pair (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Pair control and outputs
	pcm_pair_if.pair pif
);
	import pcm_pkg::*;

	typedef struct packed {
		logic a;
		logic b;
		logic [DB_W-1:0] cnt;
	} pcm_pair_s;

	pcm_pair_s cur;
	pcm_pair_s next_cur;

	always_comb begin
		next_cur = cur;
		if (!pif.run) begin
			next_cur.a = 1'b0;
			next_cur.b = 1'b0;
			next_cur.cnt = DB_RESET;
		end else if (!pif.sel_b) begin
			next_cur.b = 1'b0;
			if (cur.b) begin
				next_cur.cnt = DB_RESET;
			end else if (!cur.a) begin
				if (cur.cnt >= pif.dead) begin
					next_cur.a = 1'b1;
				end else begin
					next_cur.cnt = cur.cnt + 1'b1;
				end
			end
		end else begin
			next_cur.a = 1'b0;
			if (cur.a) begin
				next_cur.cnt = DB_RESET;
			end else if (!cur.b) begin
				if (cur.cnt >= pif.dead) begin
					next_cur.b = 1'b1;
				end else begin
					next_cur.cnt = cur.cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	assign pif.out_a = cur.a;
	assign pif.out_b = cur.b;
endmodule : pcm_pair

// >>> design/pcm_pair_if.sv
interface pcm_pair_if;
	import pcm_pkg::*;
	logic run;
	logic sel_b;
	logic [DB_W-1:0] dead;
	logic out_a;
	logic out_b;
	modport ctl (output run, output sel_b, output dead, input out_a, input out_b);
	modport pair (input run, input sel_b, input dead, output out_a, output out_b);
endinterface : pcm_pair_if

// >>> design/pcm_pkg.sv
package pcm_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int PWM_HZ = 100_000;
	// Up-down counter: one half period counts each way
	localparam int HALF_CNT = CLK_HZ / (2 * PWM_HZ);
	localparam int CNT_W = 11;
	localparam int REF_W = 12;
	localparam int SLOPE_W = 8;
	localparam int DB_W = 14;
	localparam logic [CNT_W-1:0] HALF_TOP = CNT_W'(HALF_CNT);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CNT - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
	localparam logic [DB_W-1:0] DB_RESET = 14'h0000;
	localparam logic [REF_W-1:0] SAMPLE_RESET = 12'h000;
endpackage : pcm_pkg

// >>> testbench/pcm_bridge_assertions.sv
module pcm_bridge_assertions (
	// Clock and settings
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic output_enable_flag,
	input wire logic [pcm_pkg::DB_W-1:0] active_to_passive_deadband,
	// Gates and status
	input wire logic q1,
	input wire logic q4,
	input wire logic q2,
	input wire logic q3,
	input wire logic q5,
	input wire logic q6,
	input wire logic ctrl_irq,
	input wire logic trip_seen,
	input wire logic [pcm_pkg::REF_W-1:0] adc_monitor
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcm_pkg::*;
	logic [15:0] gap;
	logic [15:0] per;
	logic seen;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 16'h0000;
			per <= 16'h0000;
			seen <= 1'b0;
		end else begin
			gap <= ($fell(q2) || $fell(q3)) ? 16'h0000 : gap + 16'h0001;
			per <= ctrl_irq ? 16'h0000 : per + 16'h0001;
			seen <= seen | ctrl_irq;
		end
	end
	leg_one_a: assert property (!(q1 && q4)) else $error("q1 q4 overlap");
	leg_two_a: assert property (!(q2 && q3)) else $error("q2 q3 overlap");
	rect_pair_a: assert property (!(q5 && q6)) else $error("q5 q6 overlap");
	gate_off_a: assert property (!output_enable_flag |=> {q1, q4, q2, q3, q5, q6} == 6'h00)
		else $error("gate high while off");
	irq_period_a: assert property (ctrl_irq && seen |-> per == 16'h07CF)
		else $error("irq period");
	trip_drop_a: assert property ($rose(trip_seen) && q2 |-> ##[1:2] !q2)
		else $error("q2 not dropped");
	leg_dead_a: assert property ($rose(q2) || $rose(q3) |-> gap >= {2'b00, active_to_passive_deadband})
		else $error("dead band short");
	adc_hold_a: assert property (!$past(ctrl_irq) && !$past(ctrl_irq, 2) |-> $stable(adc_monitor))
		else $error("monitor moved");
endmodule // pcm_bridge_assertions

// >>> testbench/pcm_sense_model.sv
module pcm_sense_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bridge gates
	input wire logic q1,
	input wire logic q4,
	input wire logic q2,
	input wire logic q3,
	// Sensed current
	output logic [pcm_pkg::REF_W-1:0] i_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcm_pkg::*;
	// Current builds only while a diagonal conducts
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			i_sense <= 12'h000;
		end else begin
			i_sense <= ((q1 && q3) || (q4 && q2)) ? i_sense + 12'h004 : 12'h000;
		end
	end
endmodule // pcm_sense_model

// >>> testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pcm_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic pk = 1'b1;
	logic [CNT_W-1:0] ph = 11'h000;
	logic [REF_W-1:0] adc = 12'h000;
	logic [DB_W-1:0] apd = 14'h0004;
	logic [DB_W-1:0] rdb = 14'h0000;
	logic [REF_W-1:0] isn;
	logic [REF_W-1:0] mon;
	logic q1, q4, q2, q3, q5, q6, irq, trip, a;
	logic [1:0] s;
	int n_errors = 0;
	int checks_done = 0;
	int i;
	always #2.5 ref_clk = ~ref_clk;
	pcm_bridge dut_u (.ref_clk, .rst_n, .ce(1'b1), .output_enable_flag(en),
		.peak_mode_select(pk), .phase_shift_setting(ph), .peak_ref(12'h040),
		.slope_step(8'h01), .master_deadband(14'h0004),
		.active_to_passive_deadband(apd), .rect_deadband(rdb),
		.i_sense(isn), .adc_sample(adc), .q1, .q4, .q2, .q3, .q5, .q6,
		.ctrl_irq(irq), .trip_seen(trip), .adc_monitor(mon));
	pcm_sense_model sense_u (.ref_clk, .rst_n, .q1, .q4, .q2, .q3, .i_sense(isn));
	task chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Spent bound ends the run
	task lim(input bit ok);
		if (!ok) begin
			chk(1'b0, "wait timed out");
			end_sim;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task t_irq;
		for (i = 0; i < 2100 && irq !== 1'b1; i++) cyc(1);
		lim(irq === 1'b1);
		rdb = 14'h0006;
		cyc(1);
		for (i = 1; i < 2100 && irq !== 1'b1; i++) cyc(1);
		chk(i == 2000, "irq period");
		$display("irq test done");
	endtask
	task t_trip;
		en = 1'b1;
		apd = 14'h0006;
		cyc(2100);
		// Trip flag stands most of a half: catch its rise
		for (i = 0; i < 2100 && trip !== 1'b0; i++) cyc(1);
		for (i = 0; i < 2100 && trip !== 1'b1; i++) cyc(1);
		lim(trip === 1'b1);
		a = q2;
		cyc(2);
		chk({q2, q3} === 2'b00, "active not dropped");
		for (i = 0; i < 20 && (q2 | q3) !== 1'b1; i++) cyc(1);
		chk(i >= 5 && i <= 7 && q3 === a, "late or wrong side");
		cyc(10);
		chk({q5, q6} === {q2, q3}, "rectifier differs");
		$display("trip test done");
	endtask
	task t_phase;
		pk = 1'b0;
		ph = 11'h12C;
		cyc(2100);
		for (i = 0; i < 2100 && q1 !== 1'b1; i++) cyc(1);
		for (i = 0; i < 2100 && q1 !== 1'b0; i++) cyc(1);
		lim(q1 === 1'b0);
		s = {q2, q3};
		for (i = 0; i < 1100 && {q2, q3} === s; i++) cyc(1);
		chk(i >= 298 && i <= 302, "phase offset");
		$display("phase test done");
	endtask
	task t_adc;
		adc = 12'hA5C;
		cyc(4);
		for (i = 0; i < 2100 && irq !== 1'b1; i++) cyc(1);
		lim(irq === 1'b1);
		cyc(3);
		chk(mon === 12'hA5C, "adc monitor");
		en = 1'b0;
		cyc(2);
		chk({q1, q4, q2, q3, q5, q6} === 6'h00, "gates on");
		$display("adc and off test done");
	endtask
	initial begin
		cyc(5);
		rst_n = 1'b1;
		cyc(20);
		chk({q1, q4, q2, q3, q5, q6} === 6'h00, "gates after reset");
		$display("reset test done");
		t_irq;
		t_trip;
		t_phase;
		t_adc;
		end_sim;
	end
endmodule // testbench

bind pcm_bridge pcm_bridge_assertions chk_u (.ref_clk, .rst_n, .output_enable_flag,
	.active_to_passive_deadband, .q1, .q4, .q2, .q3, .q5, .q6, .ctrl_irq, .trip_seen,
	.adc_monitor);
